// ==== design/erq_pkg.sv ====
package erq_pkg;
  // ********************************
  // Queue geometry
  // ********************************
  localparam int ERQ_DEPTH = 10;
  localparam int ERQ_PTR_W = 4;
  localparam int ERQ_CNT_W = 4;
  localparam logic [ERQ_CNT_W-1:0] ERQ_FULL_CNT = 4'hA;
  localparam logic [ERQ_PTR_W-1:0] ERQ_LAST_IDX = 4'h9;
  localparam logic [ERQ_PTR_W-1:0] ERQ_PTR_RST = 4'h0;
  localparam logic [ERQ_CNT_W-1:0] ERQ_CNT_RST = 4'h0;
  // ********************************
  // Record layout
  // ********************************
  localparam int ERQ_CODE_W = 16;
  localparam int ERQ_TEXT_CHARS = 80;
  localparam int ERQ_TEXT_W = ERQ_TEXT_CHARS * 8;
  localparam logic signed [ERQ_CODE_W-1:0] ERQ_CODE_NONE = 16'h0000;
  localparam logic signed [ERQ_CODE_W-1:0] ERQ_CODE_OVFL = 16'hFEBE;
  localparam logic [ERQ_TEXT_W-1:0] ERQ_TEXT_NONE = {64'h4E6F206572726F72, 576'h0};
  localparam logic [ERQ_TEXT_W-1:0] ERQ_TEXT_OVFL = {160'h4572726F72207175657565206F766572666C6F77,
    480'h0};
endpackage : erq_pkg

// ==== design/erq_error_queue.sv ====
`timescale 1ns/1ps
// Function
// - Holds up to ten error records
// - Records come out oldest first
// - Each read removes the delivered record
// - Indicator high while any record held
// - One beep pulse per generated error
// - Full queue: newest replaced by overflow marker
// - After overflow, drop errors until a read
// - Empty read gives no-error, state unchanged
// - Clear-status and power-up empty queue
// - Factory reset, preset leave queue alone
// - Record: signed code plus 80-char text
// - Leaving error menu flushes queue
module erq_error_queue
  import erq_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Error sources
  input wire logic PUSH,
  input wire logic signed [ERQ_CODE_W-1:0] PUSH_CODE,
  input wire logic [ERQ_TEXT_W-1:0] PUSH_TEXT,
  // Reader
  input wire logic POP,
  output logic signed [ERQ_CODE_W-1:0] POP_CODE,
  output logic [ERQ_TEXT_W-1:0] POP_TEXT,
  output logic POP_VALID,
  // System commands
  input wire logic CLEAR_STATUS,
  input wire logic MENU_EXIT,
  input wire logic FACTORY_RESET,
  input wire logic PRESET,
  // Indicators
  output logic ERROR_ON,
  output logic BEEP,
  output logic [ERQ_CNT_W-1:0] COUNT
);

  // ********************************
  // Storage and pointers
  // ********************************
  logic signed [ERQ_CODE_W-1:0] code_mem [ERQ_DEPTH];
  logic [ERQ_TEXT_W-1:0] text_mem [ERQ_DEPTH];
  logic [ERQ_PTR_W-1:0] rd_ptr_r;
  logic [ERQ_PTR_W-1:0] wr_ptr_r;
  logic [ERQ_CNT_W-1:0] cnt_r;
  logic ovfl_r;
  logic flush;
  logic empty;
  logic full;
  logic do_pop;
  logic do_push;
  logic do_ovfl;
  logic [ERQ_PTR_W-1:0] newest_idx;

  // Preset and factory reset are deliberately unused here
  assign flush = CLEAR_STATUS | MENU_EXIT;
  assign empty = (cnt_r == ERQ_CNT_RST);
  assign full = (cnt_r == ERQ_FULL_CNT);
  assign do_pop = POP & ~empty;
  // Pop frees a slot first, so a simultaneous push is stored normally
  assign do_push = PUSH & (~full | do_pop);
  // Once the marker sits in place further errors are only beeped
  assign do_ovfl = PUSH & full & ~do_pop & ~ovfl_r;
  assign newest_idx = (wr_ptr_r == ERQ_PTR_RST) ? ERQ_LAST_IDX : wr_ptr_r - 4'h1;

  function automatic logic [ERQ_PTR_W-1:0] bump(input logic [ERQ_PTR_W-1:0] p);
    bump = (p == ERQ_LAST_IDX) ? ERQ_PTR_RST : p + 4'h1;
  endfunction : bump

  // ********************************
  // Pointers and count
  // ********************************
  always_ff @(posedge CLK) begin
    if (!RESETN || flush) begin
      rd_ptr_r <= ERQ_PTR_RST;
      wr_ptr_r <= ERQ_PTR_RST;
      cnt_r <= ERQ_CNT_RST;
    end else begin
      if (do_pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      if (do_push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // ********************************
  // Overflow lock
  // ********************************
  always_ff @(posedge CLK) begin
    if (!RESETN || flush) begin
      ovfl_r <= 1'b0;
    end else if (do_pop) begin
      ovfl_r <= 1'b0;
    end else if (do_ovfl) begin
      ovfl_r <= 1'b1;
    end
  end

  // ********************************
  // Record storage
  // ********************************
  // No reset on the array: contents beyond the count are never read
  always_ff @(posedge CLK) begin
    if (RESETN && !flush) begin
      if (do_push) begin
        code_mem[wr_ptr_r] <= PUSH_CODE;
        text_mem[wr_ptr_r] <= PUSH_TEXT;
      end else if (do_ovfl) begin
        code_mem[newest_idx] <= ERQ_CODE_OVFL;
        text_mem[newest_idx] <= ERQ_TEXT_OVFL;
      end
    end
  end

  // ********************************
  // Read answer
  // ********************************
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      POP_CODE <= ERQ_CODE_NONE;
      POP_TEXT <= ERQ_TEXT_NONE;
      POP_VALID <= 1'b0;
    end else begin
      POP_VALID <= POP;
      if (do_pop) begin
        POP_CODE <= code_mem[rd_ptr_r];
        POP_TEXT <= text_mem[rd_ptr_r];
      end else if (POP) begin
        POP_CODE <= ERQ_CODE_NONE;
        POP_TEXT <= ERQ_TEXT_NONE;
      end
    end
  end

  // ********************************
  // Indicators
  // ********************************
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      BEEP <= 1'b0;
    end else begin
      BEEP <= PUSH;
    end
  end

  assign ERROR_ON = ~empty;
  assign COUNT = cnt_r;

  // ********************************
  // Checks
  // ********************************
  a_count_bound: assert property (@(posedge CLK) disable iff (!RESETN) cnt_r <= ERQ_FULL_CNT)
    else $error("queue count above ten");
  a_fifo_order: assert property (@(posedge CLK) disable iff (!RESETN)
    do_pop && !flush |=> POP_CODE == $past(code_mem[rd_ptr_r]))
    else $error("read not oldest record");
  a_pop_removes: assert property (@(posedge CLK) disable iff (!RESETN)
    do_pop && !do_push && !flush |=> cnt_r == $past(cnt_r) - 4'h1)
    else $error("read did not remove record");
  a_error_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    cnt_r == 4'h1 && POP && !PUSH |=> !ERROR_ON)
    else $error("indicator stayed on after last read");
  a_beep_pulse: assert property (@(posedge CLK) disable iff (!RESETN) PUSH |=> BEEP)
    else $error("missing beep");
  a_ovfl_mark: assert property (@(posedge CLK) disable iff (!RESETN)
    do_ovfl && !flush |=> code_mem[$past(newest_idx)] == ERQ_CODE_OVFL && cnt_r == ERQ_FULL_CNT)
    else $error("overflow marker not written");
  a_ovfl_drop: assert property (@(posedge CLK) disable iff (!RESETN)
    ovfl_r && PUSH && !POP && !flush |=> $stable(wr_ptr_r) && ovfl_r)
    else $error("error stored while locked");
  a_empty_read: assert property (@(posedge CLK) disable iff (!RESETN)
    POP && empty && !PUSH && !flush |=> POP_CODE == ERQ_CODE_NONE && empty && $stable(rd_ptr_r))
    else $error("empty read misbehaved");
  a_clear_all: assert property (@(posedge CLK) disable iff (!RESETN)
    CLEAR_STATUS |=> empty && !ERROR_ON)
    else $error("clear-status did not empty");
  a_preset_keep: assert property (@(posedge CLK) disable iff (!RESETN)
    (FACTORY_RESET || PRESET) && !flush && !PUSH && !POP |=> $stable(cnt_r))
    else $error("preset changed queue");
  a_menu_flush: assert property (@(posedge CLK) disable iff (!RESETN) MENU_EXIT |=> cnt_r == 4'h0)
    else $error("menu exit did not flush");
  a_full_swap: assert property (@(posedge CLK) disable iff (!RESETN)
    full && PUSH && POP && !flush |=> full && !ovfl_r)
    else $error("pop with push on full went wrong");
  a_beep_quiet: assert property (@(posedge CLK) disable iff (!RESETN) !PUSH |=> !BEEP)
    else $error("beep without error");
  // Answer strobe follows every read, even an empty one
  a_answer_flag: assert property (@(posedge CLK) disable iff (!RESETN) POP |=> POP_VALID)
    else $error("read answer not flagged");
  a_answer_quiet: assert property (@(posedge CLK) disable iff (!RESETN) !POP |=> !POP_VALID)
    else $error("answer flagged without read");
  a_ovfl_text: assert property (@(posedge CLK) disable iff (!RESETN)
    do_ovfl && !flush |=> text_mem[$past(newest_idx)] == ERQ_TEXT_OVFL)
    else $error("overflow text not written");
  a_push_store: assert property (@(posedge CLK) disable iff (!RESETN)
    do_push && !flush |=> code_mem[$past(wr_ptr_r)] == $past(PUSH_CODE))
    else $error("error code not stored");
  a_count_grow: assert property (@(posedge CLK) disable iff (!RESETN)
    do_push && !do_pop && !flush |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("push did not add record");
  a_flag_set: assert property (@(posedge CLK) disable iff (!RESETN)
    PUSH && !flush |=> ERROR_ON)
    else $error("indicator off after error");
  a_empty_text: assert property (@(posedge CLK) disable iff (!RESETN)
    POP && empty && !flush |=> POP_TEXT == ERQ_TEXT_NONE)
    else $error("empty read text wrong");
  a_menu_flag: assert property (@(posedge CLK) disable iff (!RESETN) MENU_EXIT |=> !ERROR_ON)
    else $error("indicator on after menu exit");

endmodule : erq_error_queue

// ==== test/erq_partner.sv ====
`timescale 1ns/1ps
module erq_partner
  import erq_pkg::*;
(
  // Source and reader side
  input wire logic CLK,
  output logic PUSH,
  output logic signed [ERQ_CODE_W-1:0] PUSH_CODE,
  output logic [ERQ_TEXT_W-1:0] PUSH_TEXT,
  output logic POP
);
  initial begin
    PUSH = 1'b0;
    POP = 1'b0;
    PUSH_CODE = 16'h0000;
    PUSH_TEXT = '0;
  end
  // Idle data inverted so a stale record is never reused
  task automatic xfer(input logic p, input logic q, input logic [15:0] c);
    @(posedge CLK);
    #1;
    PUSH = p;
    POP = q;
    PUSH_CODE = c;
    PUSH_TEXT = {c, 624'h0};
    @(posedge CLK);
    #1;
    PUSH = 1'b0;
    POP = 1'b0;
    PUSH_CODE = ~c;
    PUSH_TEXT = ~PUSH_TEXT;
  endtask : xfer
endmodule : erq_partner

// ==== test/erq_error_queue_tb_top.sv ====
`timescale 1ns/1ps
module erq_error_queue_tb_top
  import erq_pkg::*;
;
  logic clk, resetn, push, pop, pop_valid, error_on, beep;
  logic signed [ERQ_CODE_W-1:0] push_code, pop_code;
  logic [ERQ_TEXT_W-1:0] push_text, pop_text;
  logic [ERQ_CNT_W-1:0] count;
  logic [3:0] cmd;
  int fail_count, comparisons, cycles;
  erq_partner i_partner (.CLK(clk), .PUSH(push), .PUSH_CODE(push_code), .PUSH_TEXT(push_text), .POP(pop));
  erq_error_queue i_dut (.CLK(clk), .RESETN(resetn), .PUSH(push), .PUSH_CODE(push_code),
    .PUSH_TEXT(push_text), .POP(pop), .POP_CODE(pop_code), .POP_TEXT(pop_text), .POP_VALID(pop_valid),
    .CLEAR_STATUS(cmd[0]), .MENU_EXIT(cmd[1]), .FACTORY_RESET(cmd[2]), .PRESET(cmd[3]),
    .ERROR_ON(error_on), .BEEP(beep), .COUNT(count));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic pulse(input int i);
    @(posedge clk);
    #1;
    cmd[i] = 1'b1;
    @(posedge clk);
    #1;
    cmd = 4'h0;
  endtask : pulse
  task automatic fill(input int n);
    for (int k = 1; k <= n; k++) i_partner.xfer(1'b1, 1'b0, k[15:0]);
  endtask : fill
  task automatic t_basic();
    i_partner.xfer(1'b1, 1'b0, 16'hFF8F);
    chk("beep", 16'h1, {15'h0, beep});
    chk("error_on", 16'h1, {15'h0, error_on});
    chk("pop_valid", 16'h0, {15'h0, pop_valid});
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", 16'hFF8F, pop_code);
    chk("text", 16'hFF8F, pop_text[639:624]);
    chk("pop_valid", 16'h1, {15'h0, pop_valid});
    chk("beep", 16'h0, {15'h0, beep});
    chk("error_on", 16'h0, {15'h0, error_on});
    i_partner.xfer(1'b0, 1'b1, 16'h0005);
    chk("code", ERQ_CODE_NONE, pop_code);
    chk("none_text", 16'h1, {15'h0, pop_text === ERQ_TEXT_NONE});
    chk("none_head", 16'h4E6F, pop_text[639:624]);
    chk("pop_valid", 16'h1, {15'h0, pop_valid});
    chk("count", 16'h0, {12'h0, count});
  endtask : t_basic
  task automatic t_full();
    fill(10);
    chk("count", 16'hA, {12'h0, count});
    i_partner.xfer(1'b1, 1'b0, 16'h00BB);
    chk("beep", 16'h1, {15'h0, beep});
    i_partner.xfer(1'b1, 1'b0, 16'h00CC);
    chk("beep", 16'h1, {15'h0, beep});
    chk("count", 16'hA, {12'h0, count});
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", 16'h1, pop_code);
    chk("count", 16'h9, {12'h0, count});
    i_partner.xfer(1'b1, 1'b0, 16'h00DD);
    for (int k = 2; k <= 9; k++) begin
      i_partner.xfer(1'b0, 1'b1, 16'h0000);
      chk("code", k[15:0], pop_code);
    end
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", ERQ_CODE_OVFL, pop_code);
    chk("ovfl_text", 16'h1, {15'h0, pop_text === ERQ_TEXT_OVFL});
    chk("ovfl_head", 16'h4572, pop_text[639:624]);
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", 16'h00DD, pop_code);
    chk("error_on", 16'h0, {15'h0, error_on});
  endtask : t_full
  task automatic t_cmds();
    fill(10);
    i_partner.xfer(1'b1, 1'b1, 16'h00EE);
    chk("code", 16'h1, pop_code);
    chk("count", 16'hA, {12'h0, count});
    pulse(2);
    pulse(3);
    chk("count", 16'hA, {12'h0, count});
    chk("error_on", 16'h1, {15'h0, error_on});
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", 16'h2, pop_code);
    pulse(0);
    chk("count", 16'h0, {12'h0, count});
    chk("error_on", 16'h0, {15'h0, error_on});
    fill(2);
    pulse(1);
    chk("count", 16'h0, {12'h0, count});
    chk("error_on", 16'h0, {15'h0, error_on});
  endtask : t_cmds
  // Reset in mid-run must drop held records and the last answer
  task automatic t_powerup();
    fill(3);
    chk("count", 16'h3, {12'h0, count});
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("count", 16'h0, {12'h0, count});
    chk("error_on", 16'h0, {15'h0, error_on});
    chk("pop_valid", 16'h0, {15'h0, pop_valid});
    chk("code", ERQ_CODE_NONE, pop_code);
    i_partner.xfer(1'b0, 1'b1, 16'h0000);
    chk("code", ERQ_CODE_NONE, pop_code);
  endtask : t_powerup
  // Whole run is about 120 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 2000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0;
    cmd = 4'h0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("count", 16'h0, {12'h0, count});
    t_basic();
    t_full();
    t_cmds();
    t_powerup();
    conclude();
  end
endmodule : erq_error_queue_tb_top
